// file: include/smac_pkg.sv
// package: register map, field layout and types of the sample memory address control block
`default_nettype none
package smac_pkg;
    localparam int          ADDR_W            = 26;
    localparam int          SAMP_W            = 12;
    localparam int          PTR_W             = 25;
    // register offsets within the group window
    localparam logic [25:0] OFS_EVENT_CONFIG  = 26'h2000000;
    localparam logic [25:0] OFS_SAMPLE_LENGTH = 26'h2000004;
    localparam logic [25:0] OFS_START_ADDRESS = 26'h2000008;
    localparam logic [25:0] OFS_INPUT_TEST    = 26'h200000C;
    localparam logic [25:0] OFS_NEXT_ADDR_1   = 26'h2000010;
    localparam logic [25:0] OFS_NEXT_ADDR_2   = 26'h2000014;
    localparam logic [25:0] OFS_LIVE_VALUE    = 26'h2000020;
    localparam logic [25:0] OFS_FIFO_CHECK    = 26'h2000028;
    localparam logic [25:0] OFS_TRIG_SETUP_1  = 26'h2000030;
    localparam logic [25:0] OFS_TRIG_SETUP_2  = 26'h2000038;
    localparam logic [25:0] OFS_KEY_ARM       = 26'h0000410;
    localparam logic [25:0] OFS_KEY_DISARM    = 26'h0000414;
    localparam logic [25:0] OFS_KEY_START     = 26'h0000418;
    localparam logic [25:0] OFS_KEY_STOP      = 26'h000041C;
    localparam logic [25:0] OFS_KEY_MEM_RESET = 26'h0000428;
    localparam logic [25:0] OFS_BCAST_CONFIG  = 26'h1000000;
    localparam logic [25:0] OFS_BCAST_LENGTH  = 26'h1000004;
    localparam logic [25:0] OFS_BCAST_START   = 26'h1000008;
    localparam logic [25:0] OFS_BCAST_TEST    = 26'h100000C;
    // event configuration fields
    localparam int          CFG_LEN_STOP_BIT  = 5;
    localparam int          CFG_PAGE_WRAP_BIT = 4;
    localparam int          CFG_PSIZE_LSB     = 0;
    localparam logic [3:0]  PSIZE_LAST_VALID  = 4'hB;
    localparam logic [4:0]  PSIZE_LOG2_MAX    = 5'h18;
    // input test mode fields
    localparam int          TST_ENABLE_BIT    = 16;
    localparam int          TST_WIDE_BIT      = 17;
    localparam logic [31:0] TST_MASK          = 32'h0003FFFF;
    // masks of writable bits, unmapped read value and last packet phase
    localparam logic [31:0] CFG_MASK          = 32'h0000143F;
    localparam logic [31:0] ADDR_MASK         = 32'h01FFFFFC;
    localparam logic [31:0] TRIG_MASK         = 32'h00FF1F1F;
    localparam logic [31:0] RESET_VALUE       = 32'h00000000;
    localparam logic [1:0]  PACKET_LAST       = 2'h3;

    typedef enum logic [1:0] {
        SMAC_IDLE     = 2'b00,
        SMAC_ARMED    = 2'b01,
        SMAC_SAMPLING = 2'b10
    } smac_state_t;

    // one host bus cycle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [25:0] addr;
        logic [31:0] wdata;
    } smac_bus_t;

    // one sample word bound for the memory
    typedef struct packed {
        logic [24:0] addr;
        logic [15:0] data1;
        logic [15:0] data2;
    } smac_word_t;
endpackage : smac_pkg
`default_nettype wire

// file: design/smac_top.sv
// sample memory address control of one two-channel group, with its sample fifo
// Notes on behaviour
// - length stop bit set: sampling stops at programmed count; clear: count never stops
// - page wrap bit picks wrap over full memory or within sized pages
// - page size codes 0..7 step 16M down by four to 1K; 8..B 512..64
// - wrap flag sets once count reaches the length value while wrapping
// - arm copies start address register into the storage pointer
// - full-memory mode: pointer steps by one each sample, stop on packet boundary
// - full-memory mode: next event starts right after previous stop
// - page mode: upper bits hold page, only in-page low bits increment
// - page mode: next event bumps page by one and clears in-page bits
// - test enable records ramp from start value; step two in 32-bit mode
// - next-address readback, one shared value at both channel offsets, bits 24:0, resets to zero
// - samples stored in packets of four; low address bits give stop position
// - live value refreshes every clock while the sample clock is present and its read is not pending
// - live word: odd channel in 27:16, even channel in 11:0
// - check register shows the one 4-bit fifo write pointer repeated in all eight nibbles
// - trigger setup holds peaking, sum gap and pulse length; 31:24 read zero
// - a write to arm key arms unless sampling; also starts when autostart set
`timescale 1ns/10ps
`default_nettype none
module smac_top
    import smac_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // host register port
    input  wire smac_bus_t   bus,
    output logic [31:0]      rdata,
    output logic             rvalid,
    // sampling control
    input  wire logic        autostart,
    input  wire logic        ext_stop,
    input  wire logic        sample_clk_present,
    // converter data, already in this clock domain
    input  wire logic [11:0] adc_odd,
    input  wire logic [11:0] adc_even,
    // memory side of the sample fifo
    output smac_word_t       mem_word,
    output logic             mem_valid,
    input  wire logic        mem_ready,
    // status
    output logic             sampling,
    output logic             armed,
    output logic             wrapped
);
    typedef struct packed {
        smac_state_t  st;
        logic [31:0]  cfg;
        logic [31:0]  len;
        logic [31:0]  start;
        logic [31:0]  tst;
        logic [31:0]  trig1;
        logic [31:0]  trig2;
        logic [24:0]  ptr;
        logic [24:0]  next_addr;
        logic [24:0]  count;
        logic         wrap;
        logic         first_event;
        logic         stop_req;
        logic [15:0]  tdata;
        logic [31:0]  live;
        logic [1:0]   phase;
        logic [31:0]  rdata;
        logic         rvalid;
    } smac_regs_t;

    smac_regs_t  r_reg;
    smac_regs_t  r_next;
    smac_word_t  push_word;
    logic        push_valid;
    logic        push_ready;
    logic [3:0]  fifo_wptr;
    logic        mem_rst;
    logic [24:0] page_mask;

    // page mask from the size code; reserved codes fall back to the smallest page
    always_comb begin
        logic [4:0] lg;
        lg = 5'h6;
        if (r_reg.cfg[3:0] <= PSIZE_LAST_VALID) begin
            if (r_reg.cfg[3]) begin
                lg = 5'h9 - {2'b00, r_reg.cfg[2:0]};
            end else begin
                lg = PSIZE_LOG2_MAX - {r_reg.cfg[3:0], 1'b0};
            end
        end
        page_mask = (25'h1 << lg) - 25'h1;
    end

    always_comb begin
        logic        is_wr;
        logic        do_arm;
        logic        do_start;
        logic        do_stop;
        logic [24:0] inc;
        logic        live_rd;
        is_wr    = bus.wr;
        do_arm   = is_wr && bus.addr == OFS_KEY_ARM;
        do_start = (is_wr && bus.addr == OFS_KEY_START) || (do_arm && autostart);
        do_stop  = is_wr && bus.addr == OFS_KEY_STOP;
        live_rd  = bus.rd && bus.addr == OFS_LIVE_VALUE;
        inc      = 25'h0;
        r_next   = r_reg;
        r_next.rvalid = bus.rd;
        r_next.rdata  = RESET_VALUE;
        push_valid = 1'b0;
        push_word  = '0;

        // register writes
        if (is_wr) begin
            unique case (bus.addr)
                OFS_EVENT_CONFIG, OFS_BCAST_CONFIG: r_next.cfg = bus.wdata & CFG_MASK;
                OFS_SAMPLE_LENGTH, OFS_BCAST_LENGTH: r_next.len = bus.wdata & ADDR_MASK;
                OFS_START_ADDRESS, OFS_BCAST_START: r_next.start = bus.wdata & ADDR_MASK;
                OFS_INPUT_TEST, OFS_BCAST_TEST:   r_next.tst = bus.wdata & TST_MASK;
                OFS_TRIG_SETUP_1:                 r_next.trig1 = bus.wdata & TRIG_MASK;
                OFS_TRIG_SETUP_2:                 r_next.trig2 = bus.wdata & TRIG_MASK;
                default: ;
            endcase
        end

        // register reads; unmapped reads answer zero
        if (bus.rd) begin
            unique case (bus.addr)
                OFS_EVENT_CONFIG:  r_next.rdata = r_reg.cfg;
                OFS_SAMPLE_LENGTH: r_next.rdata = r_reg.len;
                OFS_START_ADDRESS: r_next.rdata = r_reg.start;
                OFS_INPUT_TEST:    r_next.rdata = r_reg.tst;
                OFS_NEXT_ADDR_1,
                OFS_NEXT_ADDR_2:   r_next.rdata = {7'h0, r_reg.next_addr};
                OFS_LIVE_VALUE:    r_next.rdata = r_reg.live;
                OFS_FIFO_CHECK:    r_next.rdata = {8{fifo_wptr}};
                OFS_TRIG_SETUP_1:  r_next.rdata = r_reg.trig1;
                OFS_TRIG_SETUP_2:  r_next.rdata = r_reg.trig2;
                default:           r_next.rdata = RESET_VALUE;
            endcase
        end

        // live value freezes while its read is pending
        if (sample_clk_present && !live_rd) begin
            r_next.live = {4'h0, adc_odd, 4'h0, adc_even};
        end

        // sampling sequence
        unique case (r_reg.st)
            // arming again while armed reloads the start address
            SMAC_IDLE, SMAC_ARMED: begin
                if (do_arm) begin
                    r_next.st          = SMAC_ARMED;
                    r_next.ptr         = r_reg.start[24:0];
                    r_next.first_event = 1'b1;
                end
                if (r_reg.st == SMAC_ARMED && is_wr && bus.addr == OFS_KEY_DISARM) begin
                    r_next.st = SMAC_IDLE;
                end else if (do_start && (do_arm || r_reg.st == SMAC_ARMED)) begin
                    r_next.st       = SMAC_SAMPLING;
                    r_next.count    = 25'h0;
                    r_next.wrap     = 1'b0;
                    r_next.phase    = 2'h0;
                    r_next.stop_req = 1'b0;
                    // ramp restarts at the start value with every event
                    r_next.tdata    = r_reg.tst[15:0];
                    if (!do_arm && !r_reg.first_event && r_reg.cfg[CFG_PAGE_WRAP_BIT]) begin
                        // next page, in-page bits cleared
                        r_next.ptr = ((r_reg.ptr | page_mask) + 25'h1) & ~page_mask;
                    end
                    r_next.first_event = 1'b0;
                end
            end
            SMAC_SAMPLING: begin
                if (r_reg.cfg[CFG_PAGE_WRAP_BIT]) begin
                    // in-page bits step and wrap; page bits held
                    inc = (r_reg.ptr & ~page_mask) | ((r_reg.ptr + 25'h1) & page_mask);
                end else begin
                    inc = r_reg.ptr + 25'h1;
                end
                r_next.ptr   = inc;
                r_next.phase = r_reg.phase + 2'h1;
                r_next.count = r_reg.count + 25'h1;
                if (r_reg.tst[TST_ENABLE_BIT]) begin
                    r_next.tdata = r_reg.tdata + (r_reg.tst[TST_WIDE_BIT] ? 16'h2 : 16'h1);
                end
                if (r_reg.count == r_reg.len[24:0]) begin
                    r_next.wrap = 1'b1;
                end
                // the stop request is honoured only at a packet end
                if (r_reg.phase == PACKET_LAST && push_ready) begin
                    push_valid = 1'b1;
                end
                push_word.addr  = r_reg.ptr;
                push_word.data1 = r_reg.tst[TST_ENABLE_BIT] ? r_reg.tdata : {4'h0, adc_odd};
                push_word.data2 = r_reg.tst[TST_ENABLE_BIT] ? r_reg.tdata : {4'h0, adc_even};
                // a stop strobe is remembered until the packet end comes round
                if (do_stop || ext_stop) begin
                    r_next.stop_req = 1'b1;
                end
                if (r_reg.stop_req || do_stop || ext_stop ||
                    (r_reg.cfg[CFG_LEN_STOP_BIT] && r_reg.count >= r_reg.len[24:0])) begin
                    if (r_reg.phase == PACKET_LAST) begin
                        r_next.st        = SMAC_ARMED;
                        r_next.next_addr = inc;
                    end
                end
                // a full fifo stalls the address stream
                if (!push_ready) begin
                    r_next.ptr   = r_reg.ptr;
                    r_next.phase = r_reg.phase;
                    r_next.count = r_reg.count;
                    r_next.tdata = r_reg.tdata;
                    r_next.st    = r_reg.st;
                end
                if (is_wr && bus.addr == OFS_KEY_DISARM) begin
                    r_next.st = SMAC_IDLE;
                end
            end
            default: r_next.st = SMAC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign mem_rst = rst || (bus.wr && bus.addr == OFS_KEY_MEM_RESET);

    smac_fifo #(
        .WIDTH ($bits(smac_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (mem_rst),
        .in_data   (push_word),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .out_data  (mem_word),
        .out_valid (mem_valid),
        .out_ready (mem_ready),
        .wr_ptr    (fifo_wptr)
    );

    assign rdata    = r_reg.rdata;
    assign rvalid   = r_reg.rvalid;
    assign sampling = r_reg.st == SMAC_SAMPLING;
    assign armed    = r_reg.st != SMAC_IDLE;
    assign wrapped  = r_reg.wrap;
endmodule : smac_top

// sample fifo; output data read combinationally from the array, flags honest
module smac_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    // low write pointer bits for the check register
    output logic [3:0]            wr_ptr
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_reg;
    logic [AW:0]      rp_reg;
    logic             full;
    logic             empty;

    assign full      = (wp_reg[AW-1:0] == rp_reg[AW-1:0]) && (wp_reg[AW] != rp_reg[AW]);
    assign empty     = wp_reg == rp_reg;
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rp_reg[AW-1:0]];
    assign wr_ptr    = 4'(wp_reg);

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            if (in_valid && !full) begin
                mem[wp_reg[AW-1:0]] <= in_data;
                wp_reg <= wp_reg + 1'b1;
            end
            if (out_ready && !empty) begin
                rp_reg <= rp_reg + 1'b1;
            end
        end
    end
endmodule : smac_fifo
`default_nettype wire

// file: verif/smac_top_monitor.sv
// checker: port-level properties of the sample memory address control block
`timescale 1ns/10ps
`default_nettype none
module smac_top_monitor
    import smac_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // host side
    input wire smac_bus_t   bus,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    // sampling control and converter data
    input wire logic        autostart,
    input wire logic        ext_stop,
    input wire logic        sample_clk_present,
    input wire logic [11:0] adc_odd,
    input wire logic [11:0] adc_even,
    // memory side and status
    input wire smac_word_t  mem_word,
    input wire logic        mem_valid,
    input wire logic        mem_ready,
    input wire logic        sampling,
    input wire logic        armed,
    input wire logic        wrapped
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic rd_live;
    assign rd_live = bus.rd && (bus.addr == OFS_LIVE_VALUE);

    a_read_answer: assert property (bus.rd |=> rvalid)
        else $error("read cycle got no answer");
    a_read_quiet: assert property (!bus.rd |=> !rvalid)
        else $error("answer without a read cycle");
    a_arm_key: assert property (bus.wr && bus.addr == OFS_KEY_ARM && !sampling |=> armed)
        else $error("arm key did not arm");
    a_auto_start: assert property (bus.wr && bus.addr == OFS_KEY_ARM && autostart |=> ##[0:1] sampling)
        else $error("autostart arm did not start sampling");
    a_live_layout: assert property (rd_live |=> rdata[31:28] == 4'h0 && rdata[15:12] == 4'h0)
        else $error("live word padding not zero");
    a_live_value: assert property (rd_live && sample_clk_present && $stable(adc_odd) && $stable(adc_even)
        |=> rdata == {4'h0, $past(adc_odd), 4'h0, $past(adc_even)})
        else $error("live word does not show converter data");
    a_addr_upper: assert property (bus.rd && (bus.addr == OFS_NEXT_ADDR_1 || bus.addr == OFS_NEXT_ADDR_2)
        |=> rdata[31:25] == 7'h00)
        else $error("next address upper bits not zero");
    a_trig_upper: assert property (bus.rd && (bus.addr == OFS_TRIG_SETUP_1 || bus.addr == OFS_TRIG_SETUP_2)
        |=> rdata[31:24] == 8'h00)
        else $error("trigger setup upper byte not zero");
    a_packet_end: assert property (mem_valid |-> mem_word.addr[1:0] == PACKET_LAST)
        else $error("memory word not at packet end");
    a_fifo_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_word))
        else $error("stalled memory word changed");

    c_word_taken: cover property (mem_valid && mem_ready);
    c_word_stalled: cover property (mem_valid && !mem_ready);
    c_wrap_seen: cover property ($rose(wrapped));
endmodule : smac_top_monitor
`default_nettype wire

// file: verif/smac_mem_sink.sv
// partner model: sample memory taking words from the block's fifo
`timescale 1ns/10ps
`default_nettype none
module smac_mem_sink
    import smac_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // stall request from the bench
    input wire logic       stall,
    // fifo drain side
    input wire smac_word_t mem_word,
    input wire logic       mem_valid,
    output logic           mem_ready
);
    logic [24:0] addr_q[$];
    logic [15:0] data_q[$];
    // a busy memory refuses outright; words are only taken with ready high
    assign mem_ready = !stall;
    always @(posedge clk) begin
        if (!rst && mem_valid && mem_ready) begin
            addr_q.push_back(mem_word.addr);
            data_q.push_back(mem_word.data1);
        end
    end
endmodule : smac_mem_sink
`default_nettype wire

// file: verif/tb_top.sv
// testbench: register map, sampling addresses, page wrap, test ramp, fifo stall
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import smac_pkg::*;
;
    typedef struct packed {
        logic [25:0] a;
        logic [31:0] w;
        logic [31:0] e;
        logic        z;
    } smac_row_t;
    localparam smac_row_t ROWS [10] = '{
        '{OFS_SAMPLE_LENGTH, 32'hFFFFFFFF, 32'h01FFFFFC, 1'b1},
        '{OFS_START_ADDRESS, 32'hFFFFFFFF, 32'h01FFFFFC, 1'b1},
        '{OFS_INPUT_TEST,    32'hFFFFFFFF, 32'h0003FFFF, 1'b0},
        '{OFS_EVENT_CONFIG,  32'hFFFFFFFF, 32'h0000143F, 1'b0},
        '{OFS_TRIG_SETUP_1,  32'hFFFFFFFF, 32'h00FF1F1F, 1'b1},
        '{OFS_TRIG_SETUP_2,  32'hFFFFFFFF, 32'h00FF1F1F, 1'b1},
        '{OFS_NEXT_ADDR_1,   32'hFFFFFFFF, 32'h00000000, 1'b1},
        '{OFS_NEXT_ADDR_2,   32'hFFFFFFFF, 32'h00000000, 1'b1},
        '{OFS_FIFO_CHECK,    32'hFFFFFFFF, 32'h00000000, 1'b0},
        '{26'h2000050,       32'hFFFFFFFF, 32'h00000000, 1'b0}};
    logic        clk, rst, autostart, ext_stop, stall, rvalid, clk_ok;
    logic        mem_valid, mem_ready, sampling, armed, wrapped;
    logic [11:0] adc_odd, adc_even;
    logic [31:0] rdata, d, nxt;
    smac_bus_t   bus;
    smac_word_t  mem_word;
    int          n_fail, compares, lg;

    smac_top #(.FIFO_DEPTH(16)) dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
        .rvalid(rvalid), .autostart(autostart), .ext_stop(ext_stop), .sample_clk_present(clk_ok),
        .adc_odd(adc_odd), .adc_even(adc_even), .mem_word(mem_word), .mem_valid(mem_valid),
        .mem_ready(mem_ready), .sampling(sampling), .armed(armed), .wrapped(wrapped));
    smac_mem_sink sink (.clk(clk), .rst(rst), .stall(stall), .mem_word(mem_word),
        .mem_valid(mem_valid), .mem_ready(mem_ready));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // one idle cycle after each cycle so a strobe is never set twice in one step
    task automatic wr(input logic [25:0] a, input logic [31:0] w);
        bus.wr = 1'b1;
        bus.addr = a;
        bus.wdata = w;
        tick(1);
        bus.wr = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [25:0] a, output logic [31:0] r);
        bus.rd = 1'b1;
        bus.addr = a;
        tick(1);
        bus.rd = 1'b0;
        chk("rvalid", 32'h1, {31'h0, rvalid});
        r = rdata;
        tick(1);
    endtask : rd
    task automatic setup(input logic [31:0] cfg, input logic [31:0] len, input logic [31:0] st);
        wr(OFS_BCAST_CONFIG, cfg);
        wr(OFS_SAMPLE_LENGTH, len);
        wr(OFS_START_ADDRESS, st);
        wr(OFS_KEY_ARM, 32'h0);
    endtask : setup
    task automatic ev(input int n);
        sink.addr_q.delete();
        sink.data_q.delete();
        wr(OFS_KEY_START, 32'h0);
        tick(n);
    endtask : ev
    task automatic halt();
        wr(OFS_KEY_STOP, 32'h0);
        tick(12);
    endtask : halt
    task automatic end_sim();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    initial begin
        #100000;
        n_fail++;
        end_sim();
    end

    initial begin
        rst = 1'b1;
        bus = '0;
        autostart = 1'b0;
        ext_stop = 1'b0;
        stall = 1'b0;
        clk_ok = 1'b1;
        adc_odd = 12'hABC;
        adc_even = 12'h123;
        n_fail = 0;
        compares = 0;
        tick(4);
        rst = 1'b0;
        foreach (ROWS[i]) begin
            if (ROWS[i].z) begin
                rd(ROWS[i].a, d);
                chk("reset", 32'h0, d);
            end
            wr(ROWS[i].a, ROWS[i].w);
            rd(ROWS[i].a, d);
            chk("readback", ROWS[i].e, d);
        end
        wr(OFS_INPUT_TEST, 32'h0);
        setup(32'h0, 32'h1C, 32'h100);
        ev(60);
        chk("running", 32'h1, sampling);
        halt();
        chk("first", 32'h103, sink.addr_q[0]);
        foreach (sink.addr_q[i]) chk("step", sink.addr_q[0] + 4 * i, sink.addr_q[i]);
        rd(OFS_NEXT_ADDR_2, nxt);
        chk("next", sink.addr_q[$] + 1, nxt);
        ev(20);
        halt();
        chk("resume", nxt + 3, sink.addr_q[0]);
        // code 12 is reserved and falls back to the smallest page
        for (int c = 7; c <= 12; c++) begin
            lg = (c == 7) ? 10 : (c > 11) ? 6 : 17 - c;
            setup(32'h10 | c, (1 << lg) - 4, 32'h2000);
            ev((1 << lg) + 40);
            chk("wrap", 32'h1, wrapped);
            ext_stop = 1'b1;
            tick(8);
            ext_stop = 1'b0;
            tick(12);
            foreach (sink.addr_q[i]) chk("page", 32'h2000 >> lg, sink.addr_q[i] >> lg);
        end
        ev(20);
        halt();
        chk("page_next", 32'h2043, sink.addr_q[0]);
        setup(32'h20, 32'h1C, 32'h200);
        ev(80);
        chk("stopped", 32'h0, sampling);
        chk("words", 32'd8, sink.addr_q.size());
        // start value keeps its low byte clear of FE and FF
        for (int m = 0; m < 2; m++) begin
            wr(OFS_INPUT_TEST, 32'h10010 | (m << 17));
            setup(32'h0, 32'h1C, 32'h0);
            ev(20);
            halt();
            chk("ramp", m ? 8 : 4, sink.data_q[1] - sink.data_q[0]);
            chk("ramp_first", m ? 32'h16 : 32'h13, sink.data_q[0]);
        end
        wr(OFS_INPUT_TEST, 32'h0);
        rd(OFS_LIVE_VALUE, d);
        chk("live", 32'h0ABC0123, d);
        // without a sample clock the live word keeps its last value
        clk_ok = 1'b0;
        adc_odd = 12'h5A6;
        adc_even = 12'h3C4;
        tick(2);
        rd(OFS_LIVE_VALUE, d);
        chk("live_hold", 32'h0ABC0123, d);
        clk_ok = 1'b1;
        tick(1);
        rd(OFS_LIVE_VALUE, d);
        chk("live_new", 32'h05A603C4, d);
        wr(OFS_KEY_MEM_RESET, 32'h0);
        rd(OFS_FIFO_CHECK, d);
        chk("ptrs", 32'h0, d);
        autostart = 1'b1;
        wr(OFS_KEY_ARM, 32'h0);
        chk("auto", 32'h1, sampling);
        autostart = 1'b0;
        halt();
        stall = 1'b1;
        ev(100);
        chk("held", 32'h1, mem_valid);
        halt();
        stall = 1'b0;
        tick(40);
        chk("drained", 32'h1, sink.addr_q.size() >= 16);
        wr(OFS_KEY_DISARM, 32'h0);
        chk("disarm", 32'h0, armed);
        end_sim();
    end
endmodule : tb_top

bind smac_top smac_top_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) mon (.clk(clk), .rst(rst), .bus(bus),
    .rdata(rdata), .rvalid(rvalid), .autostart(autostart), .ext_stop(ext_stop),
    .sample_clk_present(sample_clk_present), .adc_odd(adc_odd), .adc_even(adc_even),
    .mem_word(mem_word), .mem_valid(mem_valid), .mem_ready(mem_ready), .sampling(sampling),
    .armed(armed), .wrapped(wrapped));
`default_nettype wire
